// file: common/ext_signal_pkg.sv
package ext_signal_pkg;
  // Control port functions
  typedef enum logic [2:0] {
    FN_STANDBY_REQUEST,
    FN_SAFETY_LOCKOUT,
    FN_RUN_OR_STANDBY,
    FN_RUN_OR_PAUSE,
    FN_STATE_OUTPUT
  } port_fn_e;
  // Pulse sources
  typedef enum logic [2:0] {
    SRC_MEAS_START,
    SRC_MEAS_END,
    SRC_COMPARE_ABOVE,
    SRC_COMPARE_PASS,
    SRC_COMPARE_BELOW,
    SRC_COMPARE_FAIL,
    SRC_STEP_SYNC
  } pulse_src_e;
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_OPERATE,
    ST_SUSPEND
  } op_state_e;
  localparam int CLK_HZ = 40000000;
  localparam int PULSE_SHORT_US = 10;
  localparam int PULSE_LONG_US = 100;
  localparam int PULSE_SHORT_CYC = PULSE_SHORT_US * (CLK_HZ / 1000000);
  localparam int PULSE_LONG_CYC = PULSE_LONG_US * (CLK_HZ / 1000000);
  localparam int PULSE_CNT_W = 13;
  localparam int DATA_W = 16;
endpackage : ext_signal_pkg

// file: verilog/input_sync.sv
`timescale 1ns/1ps
module input_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Pin and result
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic stage1;
  logic stage2;
  logic last;
  // Two flops before any logic looks at the pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      last <= 1'b0;
    end else if (ce) begin
      stage1 <= pin;
      stage2 <= stage1;
      last <= stage2;
    end
  end
  assign level = stage2;
  assign rise = ce & stage2 & ~last;
  assign fall = ce & ~stage2 & last;
endmodule : input_sync

// file: verilog/pulse_stretch.sv
`timescale 1ns/1ps
module pulse_stretch
  import ext_signal_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Trigger and width
  input wire logic fire,
  input wire logic long_width,
  output logic pulse_n
);
  logic [PULSE_CNT_W-1:0] count;
  wire [PULSE_CNT_W-1:0] load_value = long_width ? PULSE_CNT_W'(PULSE_LONG_CYC)
                                                 : PULSE_CNT_W'(PULSE_SHORT_CYC);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      pulse_n <= 1'b1;
    end else if (ce) begin
      if (fire) begin
        count <= load_value - PULSE_CNT_W'(1);
        pulse_n <= 1'b0;
      end else if (count != '0) begin
        count <= count - PULSE_CNT_W'(1);
      end else begin
        pulse_n <= 1'b1;
      end
    end
  end
  // Width figure held by the counter
  long_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && fire && long_width) ##1 (ce && !fire)[*8] |-> !pulse_n)
    else $error("pulse ended early");
endmodule : pulse_stretch

// file: verilog/ext_control_signal_unit.sv
`timescale 1ns/1ps
// Function
// - One selectable function on the control port, or the state output.
// - Standby request mode: input rising edge forces Standby.
// - Standby request mode: input falling does not restore Operate.
// - Lockout mode: input rising edge forces Standby.
// - Lockout mode: Operate and Suspend requests refused while input high.
// - Run/standby mode: rise gives Standby, fall gives Operate.
// - Run/pause mode: rise gives Suspend, fall gives Operate.
// - State output low in Operate, high in Standby or Suspend.
// - Sync output reports exactly one selected event source.
// - Measurement start source pulses when a measurement begins.
// - Measurement end source pulses when measurement and cycle end.
// - Comparator sources pulse on above, pass, below or fail result.
// - Step sync source pulses at each pulse-source step start.
// - Pulse width selectable as 10 us or 100 us.
// - Above if over upper, pass if within limits, below if under lower.
module ext_control_signal_unit
  import ext_signal_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  // Configuration
  input wire ext_signal_pkg::port_fn_e CONTROL_PORT_FUNCTION_SELECT,
  input wire ext_signal_pkg::pulse_src_e PULSE_SOURCE_SELECT,
  input wire logic PULSE_WIDTH_LONG,
  // Control port: pin in, pin out, output enable low while driving
  input wire logic CONTROL_PORT_IN,
  output logic CONTROL_PORT_OUT,
  output logic CONTROL_PORT_OE_N,
  // Front panel or remote requests, one-cycle pulses
  input wire logic REQ_OPERATE,
  input wire logic REQ_SUSPEND,
  input wire logic REQ_STANDBY,
  // Measurement events, one-cycle pulses
  input wire logic MEAS_START,
  input wire logic MEAS_DONE,
  input wire logic STEP_START,
  input wire logic signed [DATA_W-1:0] MEAS_VALUE,
  input wire logic signed [DATA_W-1:0] UPPER_LIMIT,
  input wire logic signed [DATA_W-1:0] LOWER_LIMIT,
  // Status
  output ext_signal_pkg::op_state_e OPERATING_STATE,
  output logic COMPARE_ABOVE,
  output logic COMPARE_PASS,
  output logic COMPARE_BELOW,
  output logic SYNC_OUT_N
);
  // ************************************************************
  // Reset release and input sampling
  // ************************************************************
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  wire in_level;
  wire in_rise;
  wire in_fall;
  input_sync u_input_sync (
    .clk(CLK),
    .rst_n(rst_n),
    .ce(CE),
    .pin(CONTROL_PORT_IN),
    .level(in_level),
    .rise(in_rise),
    .fall(in_fall)
  );

  // ************************************************************
  // Operating state
  // ************************************************************
  op_state_e state;
  op_state_e next_state;
  wire fn_standby_request = CONTROL_PORT_FUNCTION_SELECT == FN_STANDBY_REQUEST;
  wire fn_safety_lockout = CONTROL_PORT_FUNCTION_SELECT == FN_SAFETY_LOCKOUT;
  wire fn_run_or_standby = CONTROL_PORT_FUNCTION_SELECT == FN_RUN_OR_STANDBY;
  wire fn_run_or_pause = CONTROL_PORT_FUNCTION_SELECT == FN_RUN_OR_PAUSE;
  wire fn_state_output = CONTROL_PORT_FUNCTION_SELECT == FN_STATE_OUTPUT;
  // Only one of the decodes can be true, so the port has one job
  wire lockout_active = fn_safety_lockout & in_level;
  wire force_standby = (fn_standby_request | fn_safety_lockout | fn_run_or_standby)
                       & in_rise;
  wire force_operate = (fn_run_or_standby | fn_run_or_pause) & in_fall;
  wire force_suspend = fn_run_or_pause & in_rise;

  // Port edges win over panel requests; a falling edge in standby
  // request mode is simply not decoded, so Operate needs a request.
  always_comb begin
    next_state = state;
    if (force_standby) begin
      next_state = ST_STANDBY;
    end else if (force_suspend) begin
      next_state = ST_SUSPEND;
    end else if (force_operate) begin
      next_state = ST_OPERATE;
    end else if (REQ_STANDBY) begin
      next_state = ST_STANDBY;
    end else if (lockout_active) begin
      next_state = state;
    end else if (REQ_OPERATE) begin
      next_state = ST_OPERATE;
    end else if (REQ_SUSPEND) begin
      case (state)
        ST_OPERATE: next_state = ST_SUSPEND;
        ST_SUSPEND: next_state = ST_SUSPEND;
        default: next_state = state;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_STANDBY;
    end else if (CE) begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      CONTROL_PORT_OUT <= 1'b1;
      CONTROL_PORT_OE_N <= 1'b1;
    end else if (CE) begin
      CONTROL_PORT_OUT <= (next_state != ST_OPERATE);
      CONTROL_PORT_OE_N <= ~fn_state_output;
    end
  end
  assign OPERATING_STATE = state;

  // ************************************************************
  // Comparator and pulse source selection
  // ************************************************************
  wire above = MEAS_VALUE > UPPER_LIMIT;
  wire below = MEAS_VALUE < LOWER_LIMIT;
  wire pass = ~above & ~below;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      COMPARE_ABOVE <= 1'b0;
      COMPARE_PASS <= 1'b0;
      COMPARE_BELOW <= 1'b0;
    end else if (CE && MEAS_DONE) begin
      COMPARE_ABOVE <= above;
      COMPARE_PASS <= pass;
      COMPARE_BELOW <= below;
    end
  end

  // Results are judged on the done strobe, when the value is settled
  logic fire;
  always_comb begin
    case (PULSE_SOURCE_SELECT)
      SRC_MEAS_START: fire = MEAS_START;
      SRC_MEAS_END: fire = MEAS_DONE;
      SRC_COMPARE_ABOVE: fire = MEAS_DONE & above;
      SRC_COMPARE_PASS: fire = MEAS_DONE & pass;
      SRC_COMPARE_BELOW: fire = MEAS_DONE & below;
      SRC_COMPARE_FAIL: fire = MEAS_DONE & (above | below);
      SRC_STEP_SYNC: fire = STEP_START;
      default: fire = 1'b0;
    endcase
  end

  pulse_stretch u_pulse_stretch (
    .clk(CLK),
    .rst_n(rst_n),
    .ce(CE),
    .fire(fire),
    .long_width(PULSE_WIDTH_LONG),
    .pulse_n(SYNC_OUT_N)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  // Port edges first: they override anything the panel asks for
  standby_on_rise_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && in_rise && (fn_standby_request || fn_safety_lockout || fn_run_or_standby)
    |=> state == ST_STANDBY)
    else $error("rise did not force standby");

  lockout_refuse_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && fn_safety_lockout && in_level && state == ST_STANDBY |=> state == ST_STANDBY)
    else $error("lockout let state leave standby");

  no_fall_restore_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && fn_standby_request && in_fall && !REQ_OPERATE && state == ST_STANDBY
    |=> state == ST_STANDBY)
    else $error("falling edge restored operate");

  run_on_fall_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && in_fall && (fn_run_or_standby || fn_run_or_pause) |=> state == ST_OPERATE)
    else $error("fall did not give operate");

  pause_on_rise_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && in_rise && fn_run_or_pause |=> state == ST_SUSPEND)
    else $error("rise did not give suspend");

  lockout_no_run_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && fn_safety_lockout && in_level && state != ST_OPERATE |=> state != ST_OPERATE)
    else $error("lockout let operate in");

  lockout_no_pause_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && fn_safety_lockout && in_level && state != ST_SUSPEND |=> state != ST_SUSPEND)
    else $error("lockout let suspend in");

  lockout_fall_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && fn_safety_lockout && in_fall && !REQ_OPERATE && !REQ_SUSPEND && !REQ_STANDBY
    |=> $stable(state))
    else $error("lockout fall changed state");

  standby_stays_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && fn_standby_request && !REQ_OPERATE && state == ST_STANDBY |=> state == ST_STANDBY)
    else $error("standby left without request");

  // ************************************************************
  // Panel and remote requests
  // ************************************************************
  request_standby_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && REQ_STANDBY && !force_suspend && !force_operate |=> state == ST_STANDBY)
    else $error("standby request ignored");

  request_run_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && REQ_OPERATE && !REQ_STANDBY && !lockout_active && !in_rise && !in_fall
    |=> state == ST_OPERATE)
    else $error("operate request ignored");

  request_pause_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && REQ_SUSPEND && !REQ_OPERATE && !REQ_STANDBY && !lockout_active
    && !in_rise && !in_fall && state == ST_OPERATE |=> state == ST_SUSPEND)
    else $error("suspend request ignored");

  // ************************************************************
  // Control port direction and level
  // ************************************************************
  state_output_a: assert property (@(posedge CLK) disable iff (!rst_n)
    $past(CE) && !CONTROL_PORT_OE_N |-> CONTROL_PORT_OUT == (state != ST_OPERATE))
    else $error("state output level wrong");

  port_released_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && !fn_state_output |=> CONTROL_PORT_OE_N)
    else $error("port driven in an input mode");

  port_driven_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && fn_state_output |=> !CONTROL_PORT_OE_N)
    else $error("port not driven in output mode");

  edge_exclusive_a: assert property (@(posedge CLK) disable iff (!rst_n)
    !(in_rise && in_fall))
    else $error("rise and fall together");

  // ************************************************************
  // Sync output
  // ************************************************************
  pulse_on_start_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && PULSE_SOURCE_SELECT == SRC_MEAS_START && MEAS_START |=> !SYNC_OUT_N)
    else $error("no pulse on measurement start");

  pulse_on_end_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && PULSE_SOURCE_SELECT == SRC_MEAS_END && MEAS_DONE |=> !SYNC_OUT_N)
    else $error("no pulse on measurement end");

  pulse_on_step_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && PULSE_SOURCE_SELECT == SRC_STEP_SYNC && STEP_START |=> !SYNC_OUT_N)
    else $error("no pulse on step start");

  above_pulse_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && PULSE_SOURCE_SELECT == SRC_COMPARE_ABOVE && MEAS_DONE && above |=> !SYNC_OUT_N)
    else $error("no pulse on compare above");

  pass_pulse_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && PULSE_SOURCE_SELECT == SRC_COMPARE_PASS && MEAS_DONE && pass |=> !SYNC_OUT_N)
    else $error("no pulse on compare pass");

  below_pulse_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && PULSE_SOURCE_SELECT == SRC_COMPARE_BELOW && MEAS_DONE && below |=> !SYNC_OUT_N)
    else $error("no pulse on compare below");

  fail_pulse_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && PULSE_SOURCE_SELECT == SRC_COMPARE_FAIL && MEAS_DONE && (above || below)
    |=> !SYNC_OUT_N)
    else $error("no pulse on compare fail");

  // A quiet source must leave the line alone
  idle_high_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && SYNC_OUT_N && !fire |=> SYNC_OUT_N)
    else $error("sync output left rest level");

  other_source_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && PULSE_SOURCE_SELECT == SRC_STEP_SYNC && !STEP_START && SYNC_OUT_N |=> SYNC_OUT_N)
    else $error("unselected event made a pulse");

  short_width_a: assert property (@(posedge CLK) disable iff (!rst_n)
    (CE && fire && !PULSE_WIDTH_LONG) ##1 (CE && !fire)[*8] |-> !SYNC_OUT_N)
    else $error("short pulse ended early");

  // ************************************************************
  // Comparator
  // ************************************************************
  compare_class_a: assert property (@(posedge CLK) disable iff (!rst_n)
    $onehot({above, pass, below}))
    else $error("comparator classes overlap");

  compare_latch_a: assert property (@(posedge CLK) disable iff (!rst_n)
    CE && MEAS_DONE |=> $onehot({COMPARE_ABOVE, COMPARE_PASS, COMPARE_BELOW}))
    else $error("latched result not one class");
endmodule : ext_control_signal_unit

// file: verification/fixture_model.sv
`timescale 1ns/1ps
module fixture_model (
  // Fixture side
  input wire logic level,
  // Unit side of the control pin
  input wire logic oe_n,
  input wire logic dut_out,
  output logic pin
);
  // The unit owns the pin only in state output mode; otherwise the fixture drives it
  assign pin = oe_n ? level : dut_out;
endmodule : fixture_model

// file: verification/tb_ext_control_signal_unit.sv
`timescale 1ns/1ps
module tb_ext_control_signal_unit;
  import ext_signal_pkg::*;
  logic CLK = 0, RESET_N = 0, PULSE_WIDTH_LONG = 0, fix_level = 0, PIN, OUT, OE_N;
  logic SYNC_OUT_N, ABOVE, PASS, BELOW;
  logic [2:0] req_v = 0, ev_v = 0;
  logic signed [15:0] MEAS_VALUE = 0;
  port_fn_e FN = FN_STANDBY_REQUEST;
  pulse_src_e SRC = SRC_MEAS_START;
  op_state_e STATE;
  int fail_count = 0, num_checks = 0;
  int k_tab[5] = '{0, 1, 1, 1, 2};
  int v_tab[5] = '{0, 200, 0, -200, 0};
  always #12.5 CLK = ~CLK;
  ext_control_signal_unit u_dut (.CLK(CLK), .RESET_N(RESET_N), .CE(1'b1),
    .CONTROL_PORT_FUNCTION_SELECT(FN), .PULSE_SOURCE_SELECT(SRC),
    .PULSE_WIDTH_LONG(PULSE_WIDTH_LONG), .CONTROL_PORT_IN(PIN), .CONTROL_PORT_OUT(OUT),
    .CONTROL_PORT_OE_N(OE_N), .REQ_OPERATE(req_v[0]), .REQ_SUSPEND(req_v[1]),
    .REQ_STANDBY(req_v[2]), .MEAS_START(ev_v[0]), .MEAS_DONE(ev_v[1]),
    .STEP_START(ev_v[2]), .MEAS_VALUE(MEAS_VALUE), .UPPER_LIMIT(16'sh0064),
    .LOWER_LIMIT(-16'sh0064), .OPERATING_STATE(STATE), .COMPARE_ABOVE(ABOVE),
    .COMPARE_PASS(PASS), .COMPARE_BELOW(BELOW), .SYNC_OUT_N(SYNC_OUT_N));
  fixture_model u_fix (.level(fix_level), .oe_n(OE_N), .dut_out(OUT), .pin(PIN));
  task stop_test;
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick
  task req(input int k);
    @(posedge CLK) req_v[k] <= 1;
    @(posedge CLK) req_v <= 0;
    tick(1);
  endtask : req
  task set_pin(input logic l);
    @(posedge CLK) fix_level <= l;
    tick(7);
  endtask : set_pin
  task set_fn(input port_fn_e f);
    @(posedge CLK) FN <= f;
    tick(3);
  endtask : set_fn
  task strobe(input int k);
    @(posedge CLK) ev_v[k] <= 1;
    @(posedge CLK) ev_v <= 0;
    #1;
  endtask : strobe
  // Low cycles of the sync output after an event; gives up early if no pulse starts
  task fire(input int k, input int exp);
    int n;
    n = 0;
    strobe(k);
    for (int i = 0; i < 5000; i++) begin
      if (SYNC_OUT_N === 1'b0) n++;
      else if (n > 0 || i > 4) break;
      tick(1);
    end
    chk(n, exp);
  endtask : fire
  function automatic bit hit(input pulse_src_e s, input int k, input int v);
    bit up = (k == 1) && (v > 100);
    bit dn = (k == 1) && (v < -100);
    case (s)
      SRC_MEAS_START: return k == 0;
      SRC_MEAS_END: return k == 1;
      SRC_COMPARE_ABOVE: return up;
      SRC_COMPARE_PASS: return (k == 1) && !up && !dn;
      SRC_COMPARE_BELOW: return dn;
      SRC_COMPARE_FAIL: return up || dn;
      default: return k == 2;
    endcase
  endfunction : hit
  initial begin
    #(25 * 80000);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge CLK);
    RESET_N <= 1;
    tick(4);
    chk(STATE, ST_STANDBY);
    chk(SYNC_OUT_N, 1);
    req(0);
    chk(STATE, ST_OPERATE);
    set_pin(1);
    chk(STATE, ST_STANDBY);
    set_pin(0);
    chk(STATE, ST_STANDBY);
    req(0);
    set_fn(FN_SAFETY_LOCKOUT);
    set_pin(1);
    chk(STATE, ST_STANDBY);
    req(0);
    req(1);
    chk(STATE, ST_STANDBY);
    set_pin(0);
    req(0);
    chk(STATE, ST_OPERATE);
    set_fn(FN_RUN_OR_STANDBY);
    set_pin(1);
    chk(STATE, ST_STANDBY);
    set_pin(0);
    chk(STATE, ST_OPERATE);
    set_fn(FN_RUN_OR_PAUSE);
    set_pin(1);
    chk(STATE, ST_SUSPEND);
    set_pin(0);
    chk(STATE, ST_OPERATE);
    set_fn(FN_STATE_OUTPUT);
    chk({OE_N, PIN}, 0);
    req(2);
    chk(PIN, 1);
    for (int s = 0; s < 7; s++) begin
      @(posedge CLK) SRC <= pulse_src_e'(s);
      for (int j = 0; j < 5; j++) begin
        @(posedge CLK) MEAS_VALUE <= 16'(v_tab[j]);
        fire(k_tab[j], hit(pulse_src_e'(s), k_tab[j], v_tab[j]) ? PULSE_SHORT_CYC : 0);
        if (s == 0 && k_tab[j] == 1) chk({ABOVE, PASS, BELOW}, {v_tab[j] > 100,
          v_tab[j] == 0, v_tab[j] < -100});
      end
    end
    @(posedge CLK) SRC <= SRC_MEAS_START;
    strobe(0);
    tick(100);
    fire(0, PULSE_SHORT_CYC);
    @(posedge CLK) PULSE_WIDTH_LONG <= 1;
    fire(0, PULSE_LONG_CYC);
    stop_test();
  end
endmodule : tb_ext_control_signal_unit
